// file: core/ptf_pin_logic.v
// pin function logic for port B bits 3..7 and port C, with Avalon-MM registers
`timescale 1ns/1ns
`include "ptf_defines.vh"
module ptf_pin_logic #(
  parameter ADDR_WIDTH = 6
) (
  // clock, reset, enable
  input wire clock,
  input wire rst_b,
  input wire ce,
  // avalon-mm slave
  input wire [ADDR_WIDTH-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // interrupt
  output wire irq,
  // port B pins, bits 3..5 (6 and 7 are unbonded)
  input wire [5:3] portBPinIn,
  output reg [5:3] portBPinOut,
  output reg [5:3] portBPinOe,
  // port C pins
  input wire [7:0] portCPinIn,
  output reg [7:0] portCPinOut,
  output reg [7:0] portCPinOe,
  // timer compare outputs
  input wire timerCompareOut1,
  input wire timerCompareOut2,
  // serial interface
  input wire serialTransmitData,
  input wire serialShiftClockOut,
  output reg serialSlaveTransmitEnable,
  output reg serialReceiveData,
  output reg serialShiftClockIn,
  // serial mode as seen by the pins
  output wire serialSyncMode,
  output wire serialMaster
);
  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  reg rstMeta_reg;
  reg rstDone_reg;
  wire resetB;

  // runs regardless of ce so reset can always be released
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstDone_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstDone_reg <= rstMeta_reg;
    end
  end

  assign resetB = rstDone_reg;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // software value or peripheral value, by function select
  function pinMux;
    input sel;
    input swVal;
    input modVal;
    begin
      pinMux = sel ? modVal : swVal;
    end
  endfunction

  function regHit;
    input [ADDR_WIDTH-1:0] addr;
    input [5:0] offset;
    begin
      regHit = (addr[5:2] == offset[5:2]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg [7:0] bOut_reg;
  reg [7:0] bDir_reg;
  reg [7:0] bSel_reg;
  reg [7:0] bFlag_reg;
  reg [7:0] bIrqEn_reg;
  reg [7:0] bEdge_reg;
  reg [7:0] cOut_reg;
  reg [7:0] cDir_reg;
  reg [7:0] cSel_reg;
  reg [1:0] ctrl_reg;
  reg ack_reg;
  reg [7:0] bFlag_next;
  reg [31:0] readdata_next;

  wire access;
  wire wrStrobe;
  wire [7:0] wrByte;
  wire [7:0] bInValue;
  wire [7:0] cInValue;
  wire [7:0] bHwSet;

  // one wait cycle: request seen, answer on the next edge
  assign access = (read | write) & ~ack_reg;
  assign waitrequest = (read | write) & ~ack_reg;
  assign wrStrobe = write & ack_reg & byteenable[0];
  assign wrByte = writedata[7:0];

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  wire [10:0] pinLevel;
  wire [10:0] pinRise;
  wire [10:0] pinFall;

  ptf_pin_sync #(
    .WIDTH(11)
  ) pinSync (
    .clock(clock),
    .resetB(resetB),
    .ce(ce),
    .pinRaw({portCPinIn, portBPinIn}),
    .level_reg(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  // unbonded bits read zero: there is nothing to sample
  assign bInValue = {2'b00, pinLevel[2:0], 3'b000}; // R15 R5
  assign cInValue = pinLevel[10:3]; // R15

  // ----------------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------------
  // edge select low catches rising, high catches falling; only pinned bits
  // see hardware edges, so bits 6 and 7 move only by software
  assign bHwSet = {2'b00, // R6
    (bEdge_reg[5:3] & pinFall[2:0]) | (~bEdge_reg[5:3] & pinRise[2:0]), // R7
    3'b000};

  always @* begin
    bFlag_next = bFlag_reg;
    if (wrStrobe && regHit(address, `PTF_OFF_B_FLAG)) begin
      bFlag_next = bFlag_next & ~wrByte;
    end
    if (wrStrobe && regHit(address, `PTF_OFF_B_FLAG_SET)) begin
      bFlag_next = bFlag_next | wrByte; // R6
    end
    // a hardware edge in the clearing cycle is kept
    bFlag_next = (bFlag_next | bHwSet) & `PTF_B_MASK; // R7
  end

  // port C has no flag logic at all
  assign irq = |(bFlag_reg & bIrqEn_reg); // R16

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge resetB) begin
    if (!resetB) begin
      bOut_reg <= `PTF_RST_BYTE;
      bDir_reg <= `PTF_RST_BYTE;
      bSel_reg <= `PTF_RST_BYTE;
      bFlag_reg <= `PTF_RST_BYTE;
      bIrqEn_reg <= `PTF_RST_BYTE;
      bEdge_reg <= `PTF_RST_BYTE;
      cOut_reg <= `PTF_RST_BYTE;
      cDir_reg <= `PTF_RST_BYTE;
      cSel_reg <= `PTF_RST_BYTE;
      ctrl_reg <= `PTF_RST_CTRL;
      ack_reg <= 1'b0;
      readdata <= 32'h00000000;
    end else if (ce) begin
      ack_reg <= access;
      if (access) begin
        readdata <= readdata_next;
      end
      bFlag_reg <= bFlag_next;
      if (wrStrobe) begin
        if (regHit(address, `PTF_OFF_B_OUT)) begin
          bOut_reg <= wrByte & `PTF_B_MASK;
        end
        if (regHit(address, `PTF_OFF_B_DIR)) begin
          bDir_reg <= wrByte & `PTF_B_MASK;
        end
        if (regHit(address, `PTF_OFF_B_SEL)) begin
          bSel_reg <= wrByte & `PTF_B_MASK;
        end
        if (regHit(address, `PTF_OFF_B_IRQ_EN)) begin
          bIrqEn_reg <= wrByte & `PTF_B_MASK; // R7
        end
        if (regHit(address, `PTF_OFF_B_EDGE)) begin
          bEdge_reg <= wrByte & `PTF_B_MASK; // R7
        end
        if (regHit(address, `PTF_OFF_C_OUT)) begin
          cOut_reg <= wrByte;
        end
        if (regHit(address, `PTF_OFF_C_DIR)) begin
          cDir_reg <= wrByte;
        end
        if (regHit(address, `PTF_OFF_C_SEL)) begin
          cSel_reg <= wrByte;
        end
        if (regHit(address, `PTF_OFF_CTRL)) begin
          ctrl_reg <= wrByte[1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    readdata_next = 32'h00000000;
    case (address[5:2])
      4'h0: readdata_next[7:0] = bInValue;
      4'h1: readdata_next[7:0] = bOut_reg;
      4'h2: readdata_next[7:0] = bDir_reg;
      4'h3: readdata_next[7:0] = bSel_reg;
      4'h4: readdata_next[7:0] = bFlag_reg;
      4'h5: readdata_next[7:0] = bIrqEn_reg;
      4'h6: readdata_next[7:0] = bEdge_reg;
      4'h8: readdata_next[7:0] = cInValue;
      4'h9: readdata_next[7:0] = cOut_reg;
      4'ha: readdata_next[7:0] = cDir_reg;
      4'hb: readdata_next[7:0] = cSel_reg;
      4'hc: readdata_next[1:0] = ctrl_reg;
      default: readdata_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  assign serialSyncMode = ctrl_reg[`PTF_CTRL_SYNC_BIT];
  assign serialMaster = ctrl_reg[`PTF_CTRL_MASTER_BIT];

  reg [5:3] bPinOut_next;
  reg [5:3] bPinOe_next;
  reg [7:0] cPinOut_next;
  reg [7:0] cPinOe_next;

  always @* begin
    // port B: direction never comes from the peripheral
    bPinOe_next = bDir_reg[5:3]; // R1 R3
    bPinOut_next[3] = pinMux(bSel_reg[3], bOut_reg[3], timerCompareOut1); // R2 R15
    bPinOut_next[4] = pinMux(bSel_reg[4], bOut_reg[4], timerCompareOut2); // R3 R15
    bPinOut_next[5] = pinMux(bSel_reg[5], bOut_reg[5], 1'b0); // R4

    // port C default: software control, peripheral source low
    cPinOe_next = cDir_reg;
    cPinOut_next = cOut_reg & ~cSel_reg; // R15 R11
    if (cSel_reg[0]) begin
      cPinOe_next[0] = 1'b0; // R8
    end
    if (cSel_reg[3]) begin
      // clock pin is output only as synchronous master
      cPinOe_next[3] = serialSyncMode & serialMaster; // R12 R14
      cPinOut_next[3] = pinMux(cSel_reg[3], cOut_reg[3], serialShiftClockOut); // R14
    end
    if (cSel_reg[4]) begin
      cPinOe_next[4] = 1'b1; // R9
      cPinOut_next[4] = pinMux(cSel_reg[4], cOut_reg[4], serialTransmitData); // R9
    end
    if (cSel_reg[5]) begin
      cPinOe_next[5] = 1'b0; // R10
    end
    if (cSel_reg[6]) begin
      cPinOe_next[6] = 1'b0; // R11
    end
    if (cSel_reg[7]) begin
      cPinOe_next[7] = 1'b0; // R11
    end
  end

  // ----------------------------------------------------------------------
  // registered pin and peripheral outputs
  // ----------------------------------------------------------------------
  // registering costs one cycle on peripheral paths but keeps pins glitch free
  always @(posedge clock or negedge resetB) begin
    if (!resetB) begin
      portBPinOut <= 3'h0;
      portBPinOe <= 3'h0;
      portCPinOut <= 8'h00;
      portCPinOe <= 8'h00;
      serialSlaveTransmitEnable <= 1'b0;
      serialReceiveData <= 1'b1;
      serialShiftClockIn <= 1'b0;
    end else if (ce) begin
      portBPinOut <= bPinOut_next;
      portBPinOe <= bPinOe_next;
      portCPinOut <= cPinOut_next;
      portCPinOe <= cPinOe_next;
      serialSlaveTransmitEnable <= cSel_reg[0] & cInValue[0]; // R8
      // idle line level is high when the function is not selected
      serialReceiveData <= cSel_reg[5] ? cInValue[5] : 1'b1; // R10
      // external clock feeds the shifter when the clock function is selected, unless we are the synchronous master
      serialShiftClockIn <= cSel_reg[3] & ~(serialSyncMode & serialMaster)
        & cInValue[3]; // R13 R12
    end
  end
endmodule

// file: core/ptf_defines.vh
// register map, reset values and field positions of the port B/C pin function logic
// Overview of operation
// R1: port B bit 3 direction always from software
// R2: port B bit 3 function drives compare output 1
// R3: port B bit 4 function drives compare output 2
// R4: port B bit 5 function output tied low
// R5: port B bits 6, 7 unbonded, bits still exist
// R6: bits 6, 7 flags changed only by software
// R7: each port B bit has enable, flag, edge
// R8: port C bit 0 function: input to slave enable
// R9: port C bit 4 function: output transmit data
// R10: port C bit 5 function: input receive data
// R11: port C bits 6, 7 function: input, low
// R12: asynchronous mode forces serial clock pin input
// R13: slave mode shifts on external clock
// R14: master mode drives shift clock on pin
// R15: select picks software or peripheral; input follows pin
// R16: port C has no interrupt bits
`ifndef PTF_DEFINES_VH
`define PTF_DEFINES_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PTF_OFF_B_IN 6'h00
`define PTF_OFF_B_OUT 6'h04
`define PTF_OFF_B_DIR 6'h08
`define PTF_OFF_B_SEL 6'h0c
`define PTF_OFF_B_FLAG 6'h10
`define PTF_OFF_B_IRQ_EN 6'h14
`define PTF_OFF_B_EDGE 6'h18
`define PTF_OFF_B_FLAG_SET 6'h1c
`define PTF_OFF_C_IN 6'h20
`define PTF_OFF_C_OUT 6'h24
`define PTF_OFF_C_DIR 6'h28
`define PTF_OFF_C_SEL 6'h2c
`define PTF_OFF_CTRL 6'h30

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define PTF_RST_BYTE 8'h00
`define PTF_RST_CTRL 2'h0
`define PTF_CTRL_SYNC_BIT 0
`define PTF_CTRL_MASTER_BIT 1
// port B bits that live in this block
`define PTF_B_MASK 8'hf8
// port B bits that have a pin
`define PTF_B_PIN_MASK 8'h38
`define PTF_B_SW_ONLY_MASK 8'hc0

`endif

// file: core/ptf_pin_sync.v
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module ptf_pin_sync #(
  parameter WIDTH = 11
) (
  // clock and reset
  input wire clock,
  input wire resetB,
  input wire ce,
  // raw pins
  input wire [WIDTH-1:0] pinRaw,
  // filtered level and edges
  output reg [WIDTH-1:0] level_reg,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  reg [WIDTH-1:0] levelPrev_reg;
  reg [WIDTH-1:0] level_next;
  integer i;

  // ----------------------------------------------------------------------
  // stage 1 feeds only stage 2
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge resetB) begin
    if (!resetB) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
      level_reg <= {WIDTH{1'b0}};
      levelPrev_reg <= {WIDTH{1'b0}};
    end else if (ce) begin
      stage1_reg <= pinRaw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= level_next;
      levelPrev_reg <= level_reg;
    end
  end

  // a change counts only once stages 2 and 3 agree
  always @* begin
    level_next = level_reg;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (stage2_reg[i] == stage3_reg[i]) begin
        level_next[i] = stage3_reg[i];
      end
    end
  end

  assign rise = level_reg & ~levelPrev_reg;
  assign fall = ~level_reg & levelPrev_reg;
endmodule

// file: tb/ptf_pin_props.sv
// assertion checker for the port B/C pin function logic
`timescale 1ns/1ns
module ptf_pin_props (
  // clock and reset
  input wire clock,
  input wire rst_b,
  input wire ce,
  // register bus and interrupt
  input wire read,
  input wire write,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire irq,
  // pins and serial
  input wire [7:0] portCPinOe,
  input wire serialSlaveTransmitEnable,
  input wire serialReceiveData,
  input wire serialShiftClockIn,
  input wire serialSyncMode,
  input wire serialMaster
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence reqTaken;
    (read || write) && waitrequest && ce;
  endsequence
  sequence masterHeld;
    (serialSyncMode && serialMaster) [*2];
  endsequence
  wait_one_a: assert property (reqTaken |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  wait_idle_a: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high with no request");
  rdata_hold_a: assert property (!(read || write) |=> $stable(readdata))
    else $error("read data moved with no access");
  rdata_upper_a: assert property (readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  ste_input_a: assert property (serialSlaveTransmitEnable |-> !portCPinOe[0])
    else $error("slave enable pin driven while selected");
  rxd_input_a: assert property (!serialReceiveData |-> !portCPinOe[5])
    else $error("receive pin driven while selected");
  clk_input_a: assert property (serialShiftClockIn |-> !portCPinOe[3])
    else $error("shift clock pin driven while listening");
  master_clk_a: assert property (masterHeld |-> !serialShiftClockIn)
    else $error("shift clock taken from pin in master mode");
  irq_clear_a: assert property ($fell(irq) |-> $past(write) || $past(write, 2))
    else $error("interrupt dropped without a write");
endmodule

bind ptf_pin_logic ptf_pin_props u_props (
  .clock(clock), .rst_b(rst_b), .ce(ce), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .portCPinOe(portCPinOe),
  .serialSlaveTransmitEnable(serialSlaveTransmitEnable),
  .serialReceiveData(serialReceiveData), .serialShiftClockIn(serialShiftClockIn),
  .serialSyncMode(serialSyncMode), .serialMaster(serialMaster)
);

// file: tb/ptf_pin_partner.sv
// outside circuits on the pads: resolve each pad level
`timescale 1ns/1ns
module ptf_pin_partner (
  // device side
  input wire [5:3] portBPinOut,
  input wire [5:3] portBPinOe,
  input wire [7:0] portCPinOut,
  input wire [7:0] portCPinOe,
  // levels the outside circuits apply
  input wire [5:3] extB,
  input wire [7:0] extC,
  // resolved pads
  output wire [5:3] portBPinIn,
  output wire [7:0] portCPinIn
);
  // a driving device wins; a released pad shows the outside level
  assign portBPinIn = (portBPinOe & portBPinOut) | (~portBPinOe & extB);
  // the outside master owns the shift clock pad while the device listens
  assign portCPinIn = (portCPinOe & portCPinOut) | (~portCPinOe & extC);
endmodule

// file: tb/tb_top.sv
// self-checking bench for the port B/C pin function logic
`timescale 1ns/1ns
`include "ptf_defines.vh"
module tb_top;
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg ce = 1'b1;
  reg [5:0] address = 6'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] byteenable = 4'h1;
  reg tmr1 = 1'b0;
  reg tmr2 = 1'b0;
  reg txd = 1'b0;
  reg sclkOut = 1'b0;
  reg [5:3] extB = 3'h0;
  reg [7:0] extC = 8'h00;
  reg [7:0] q;
  reg [5:0] a;
  wire [31:0] readdata;
  wire waitrequest, irq, ste, rxd, sclkIn, syncMode, isMaster;
  wire [5:3] bIn, bOut, bOe;
  wire [7:0] cIn, cOut, cOe;
  integer errorCnt = 0;
  integer samplesChecked = 0;
  integer cycles = 0;
  always #5 clock = ~clock;
  ptf_pin_logic DUT (
    .clock(clock), .rst_b(rst_b), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .portBPinIn(bIn), .portBPinOut(bOut), .portBPinOe(bOe),
    .portCPinIn(cIn), .portCPinOut(cOut), .portCPinOe(cOe),
    .timerCompareOut1(tmr1), .timerCompareOut2(tmr2),
    .serialTransmitData(txd), .serialShiftClockOut(sclkOut),
    .serialSlaveTransmitEnable(ste), .serialReceiveData(rxd),
    .serialShiftClockIn(sclkIn), .serialSyncMode(syncMode), .serialMaster(isMaster)
  );
  ptf_pin_partner pads (
    .portBPinOut(bOut), .portBPinOe(bOe), .portCPinOut(cOut), .portCPinOe(cOe),
    .extB(extB), .extC(extC), .portBPinIn(bIn), .portCPinIn(cIn)
  );
  // ----------------------------------------
  // bus master, compare and close
  // ----------------------------------------
  task closeOut;
    begin
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
        errorCnt = errorCnt + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // waitrequest is sampled at the rising edge, before that edge updates it;
  // the leading edge keeps a release and the next request in separate steps
  task acc(input w, input [5:0] ad, input [7:0] d);
    begin
      @(posedge clock);
      address <= ad;
      writedata <= {24'h0, d};
      read <= ~w;
      write <= w;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task wr(input [5:0] ad, input [7:0] d);
    acc(1'b1, ad, d);
  endtask
  task rd(input [5:0] ad, input [7:0] e);
    begin
      acc(1'b0, ad, 8'h00);
      chk(q, e);
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clock);
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errorCnt = errorCnt + 1;
      closeOut;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    idle(3);
    for (a = 6'h00; a != 6'h38; a = a + 6'h04) rd(a, 8'h00);
    wr(6'h34, 8'hff);
    rd(6'h34, 8'h00);
    byteenable <= 4'h0;
    wr(`PTF_OFF_C_OUT, 8'hff);
    byteenable <= 4'h1;
    rd(`PTF_OFF_C_OUT, 8'h00);
    $display("test reset done");
    wr(`PTF_OFF_B_OUT, 8'hff);
    rd(`PTF_OFF_B_OUT, `PTF_B_MASK);
    wr(`PTF_OFF_B_DIR, 8'h38);
    wr(`PTF_OFF_B_OUT, 8'h28);
    idle(6);
    chk(bOe, 3'h7);
    chk(bOut, 3'h5);
    rd(`PTF_OFF_B_IN, 8'h28);
    tmr1 <= 1'b1;
    wr(`PTF_OFF_B_SEL, 8'hf8);
    idle(2);
    chk(bOut, 3'h1);
    chk(bOe, 3'h7);
    tmr1 <= 1'b0;
    tmr2 <= 1'b1;
    idle(2);
    chk(bOut, 3'h2);
    wr(`PTF_OFF_B_DIR, 8'h00);
    idle(6);
    chk(bOe, 3'h0);
    rd(`PTF_OFF_B_FLAG, 8'h38);
    wr(`PTF_OFF_B_FLAG, 8'hff);
    rd(`PTF_OFF_B_FLAG, 8'h00);
    chk(irq, 1'b0);
    $display("test port b done");
    wr(`PTF_OFF_C_DIR, 8'hff);
    wr(`PTF_OFF_C_OUT, 8'hff);
    extC <= 8'h01;
    wr(`PTF_OFF_C_SEL, 8'hf1);
    idle(2);
    chk(cOe, 8'h1e);
    chk(cOut, 8'h0e);
    txd <= 1'b1;
    idle(6);
    chk(cOut, 8'h1e);
    chk(ste, 1'b1);
    chk(rxd, 1'b0);
    rd(`PTF_OFF_C_IN, 8'h1f);
    rd(`PTF_OFF_B_FLAG, 8'h00);
    $display("test port c done");
    wr(`PTF_OFF_C_SEL, 8'h08);
    extC <= 8'h08;
    idle(6);
    chk(cOe[3], 1'b0);
    chk(sclkIn, 1'b1);
    wr(`PTF_OFF_CTRL, 8'h01);
    idle(2);
    chk({isMaster, syncMode}, 2'h1);
    chk(cOe[3], 1'b0);
    chk(sclkIn, 1'b1);
    sclkOut <= 1'b1;
    wr(`PTF_OFF_CTRL, 8'h03);
    idle(2);
    chk({cOe[3], cOut[3], sclkIn}, 3'h6);
    chk({isMaster, syncMode}, 2'h3);
    sclkOut <= 1'b0;
    idle(2);
    chk(cOut[3], 1'b0);
    // clock enable low freezes the pin registers
    ce <= 1'b0;
    sclkOut <= 1'b1;
    idle(4);
    chk(cOut[3], 1'b0);
    ce <= 1'b1;
    idle(2);
    chk(cOut[3], 1'b1);
    rd(`PTF_OFF_CTRL, 8'h03);
    $display("test shift clock done");
    wr(`PTF_OFF_B_IRQ_EN, 8'hc0);
    wr(`PTF_OFF_B_FLAG_SET, 8'h40);
    idle(2);
    chk(irq, 1'b1);
    rd(`PTF_OFF_B_FLAG_SET, 8'h00);
    rd(`PTF_OFF_B_FLAG, 8'h40);
    wr(`PTF_OFF_B_FLAG, 8'h40);
    idle(2);
    chk(irq, 1'b0);
    wr(`PTF_OFF_B_FLAG_SET, 8'h80);
    wr(`PTF_OFF_B_IRQ_EN, 8'h00);
    idle(2);
    chk(irq, 1'b0);
    wr(`PTF_OFF_B_IRQ_EN, 8'h80);
    idle(2);
    chk(irq, 1'b1);
    wr(`PTF_OFF_B_FLAG, 8'hff);
    wr(`PTF_OFF_B_EDGE, 8'h10);
    wr(`PTF_OFF_B_IRQ_EN, 8'h10);
    extB <= 3'h2;
    idle(8);
    chk(irq, 1'b0);
    extB <= 3'h0;
    idle(8);
    chk(irq, 1'b1);
    rd(`PTF_OFF_B_FLAG, 8'h10);
    $display("test interrupt done");
    closeOut;
  end
endmodule
